// File: sdci_card_info.sv
`timescale 1ns/100ps
module sdci_card_info import sdci_pkg::*; #(
  parameter logic [7:0]       MAKER_CODE   = 8'h5A,       // Arbitrary value
  parameter logic [15:0]      OEM_CODE     = 16'h4B4C,    // Arbitrary value
  parameter logic [39:0]      PRODUCT_NAME = 40'h4D_4E_4F_50_51,
  parameter logic [7:0]       PRODUCT_REV  = 8'h10,
  parameter logic [31:0]      SERIAL_NUM   = 32'h0000_0001,
  parameter logic [11:0]      MFG_DATE     = 12'h001,
  parameter logic [RCA_W-1:0] RCA_VALUE    = 16'h0001,
  parameter logic [CSD_W-1:0] CSD_IMAGE    = 128'h1,
  parameter logic [SCR_W-1:0] SCR_IMAGE    = 64'h0,
  parameter logic [SSR_W-1:0] SSR_IMAGE    = 512'h0
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Card pins, host clocked
  input  wire logic sd_clk_pin,
  input  wire logic cmd_in,
  output logic      cmd_out,
  output logic      cmd_oe,
  // Status
  output logic      card_ready
);

  typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_RX, ST_GAP, ST_TX} sdci_state_t;

  sdci_state_t            state_q;
  sdci_rsp_t              rsp_q;
  logic                   clk_s1_q, clk_s2_q, clk_s3_q;
  logic                   cmd_s1_q, cmd_s2_q;
  logic [INIT_CNT_W-1:0]  init_cnt_q;
  logic                   init_done_q;
  logic [MW_AW-1:0]       load_idx_q;
  logic [MW_AW-1:0]       raddr_q;
  logic [CMD_LEN-1:0]     rx_q;
  logic [5:0]             rx_cnt_q;
  logic                   app_q;
  logic [5:0]             idx_q;
  logic [31:0]            pay_q;
  logic [1:0]             gap_q;
  logic [LONG_LEN-1:0]    tx_q;
  logic [7:0]             tx_cnt_q;
  logic [CID_W-1:0]       mem_rdata;

  // Register images, fixed except the busy bit of ocr_word, which follows init_done_q
  wire [119:0]     cid_body = {MAKER_CODE, OEM_CODE, PRODUCT_NAME, PRODUCT_REV,
                               SERIAL_NUM, 4'h0, MFG_DATE};             // [R05] [R06]
  wire [CID_W-1:0] cid_word = {cid_body, crc7(cid_body), 1'b1};        // [R07]
  wire [OCR_W-1:0] ocr_word = {init_done_q, 1'b0, 5'h00, 1'b0,         // [R01] [R03] [R04]
                               OCR_VWIN_ALL, 15'h0000};                 // [R02] [R04]

  // Load data for the word store; status block fills four words
  wire [1:0]       ssr_sel   = 2'(load_idx_q - MW_SSR0);
  wire [CID_W-1:0] ssr_chunk = SSR_IMAGE[(3 - ssr_sel) * 128 +: 128];
  wire [CID_W-1:0] load_word = (load_idx_q == MW_CID) ? cid_word :
                               (load_idx_q == MW_CSD) ? CSD_IMAGE :
                               (load_idx_q == MW_SCR) ? {64'h0, SCR_IMAGE} : ssr_chunk; // [R08]
  wire             mem_we    = (state_q == ST_LOAD);

  // Edges of the host clock, read only after the second stage
  wire sd_rise = clk_s2_q & ~clk_s3_q;
  wire sd_fall = ~clk_s2_q & clk_s3_q;

  // Command decode on the last bit of a frame
  wire [CMD_LEN-1:0] rx_full  = {rx_q[CMD_LEN-2:0], cmd_s2_q};
  wire [5:0]         cmd_idx  = rx_full[45:40];
  wire               frame_ok = rx_full[46] & rx_full[0];
  wire               rx_done  = (state_q == ST_RX) && sd_rise && (rx_cnt_q == 6'(CMD_LEN - 1));
  wire               is_cid   = (cmd_idx == CMD_ALL_CID) || (cmd_idx == CMD_SEND_CID);  // [R11]
  wire               is_ocr   = app_q && (cmd_idx == ACMD_OP_COND);
  // Driver-stage command is not recognised and gets no response
  wire sdci_rsp_t    rsp_sel  = !frame_ok ? RSP_NONE :
                                is_ocr ? RSP_OCR :
                                (is_cid || cmd_idx == CMD_SEND_CSD) ? RSP_LONG :
                                (cmd_idx == CMD_SEND_RCA || cmd_idx == CMD_APP) ? RSP_SHORT :
                                RSP_NONE;                                // [R09]
  wire [31:0]        pay_sel  = (cmd_idx == CMD_APP) ? R1_APP_STATUS : {RCA_VALUE, 16'h0000};

  // Response images, left aligned so the MSB leaves first
  wire [LONG_LEN-1:0] img_long  = {2'b00, IDX_ALL_ONES, mem_rdata[CID_W-1:1], 1'b1};
  wire [LONG_LEN-1:0] img_short = {2'b00, idx_q, pay_q, crc7({80'h0, 2'b00, idx_q, pay_q}),
                                   1'b1, 88'h0};
  wire [LONG_LEN-1:0] img_ocr   = {2'b00, IDX_ALL_ONES, ocr_word, CRC_ALL_ONES, 1'b1, 88'h0};
  wire [LONG_LEN-1:0] tx_img    = (rsp_q == RSP_LONG) ? img_long :
                                  (rsp_q == RSP_OCR) ? img_ocr : img_short;
  wire [7:0]          tx_len    = (rsp_q == RSP_LONG) ? 8'(LONG_LEN - 1) : 8'(CMD_LEN - 1);
  wire                tx_load   = (state_q == ST_GAP) && sd_fall && (gap_q == 2'(NCR_EDGES - 1));

  // Word store for identification, specific data, configuration and status
  sdci_word_mem #(
    .WIDTH (CID_W),
    .DEPTH (MW_DEPTH),
    .AW    (MW_AW)
  ) u_mem (
    .sys_clk (sys_clk),
    .clk_en  (clk_en),
    .we      (mem_we),
    .waddr   (load_idx_q),
    .wdata   (load_word),
    .raddr   (raddr_q),
    .rdata   (mem_rdata)
  );

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {clk_s1_q, clk_s2_q, clk_s3_q} <= 3'h0;
      {cmd_s1_q, cmd_s2_q}           <= 2'h3;
    end else if (clk_en) begin
      {clk_s1_q, clk_s2_q, clk_s3_q} <= {sd_clk_pin, clk_s1_q, clk_s2_q};
      {cmd_s1_q, cmd_s2_q}           <= {cmd_in, cmd_s1_q};
    end
  end

  // Power-up timer; busy reads until it expires
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_q  <= '0;
      init_done_q <= 1'b0;
    end else if (clk_en && !init_done_q) begin
      init_cnt_q  <= init_cnt_q + 1'b1;
      init_done_q <= (init_cnt_q == INIT_LAST);                    // [R01]
    end
  end

  // Frame receiver, response scheduler and MSB-first shifter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_LOAD;
      rsp_q      <= RSP_NONE;
      load_idx_q <= '0;
      raddr_q    <= '0;
      rx_q       <= '0;
      rx_cnt_q   <= '0;
      app_q      <= 1'b0;
      idx_q      <= '0;
      pay_q      <= '0;
      gap_q      <= '0;
      tx_q       <= '0;
      tx_cnt_q   <= '0;
      cmd_out    <= 1'b1;
      cmd_oe     <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        ST_LOAD: begin
          load_idx_q <= load_idx_q + 1'b1;
          if (load_idx_q == MW_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (sd_rise && !cmd_s2_q) begin
            rx_q     <= '0;
            rx_cnt_q <= 6'h01;
            state_q  <= ST_RX;
          end
        end
        ST_RX: begin
          if (sd_rise) begin
            rx_q     <= rx_full;
            rx_cnt_q <= rx_cnt_q + 1'b1;
          end
          if (rx_done) begin
            rsp_q   <= rsp_sel;
            idx_q   <= cmd_idx;
            pay_q   <= pay_sel;
            raddr_q <= (cmd_idx == CMD_SEND_CSD) ? MW_CSD : MW_CID;
            gap_q   <= '0;
            // Application prefix lasts for exactly one following command
            app_q   <= frame_ok && (cmd_idx == CMD_APP);
            state_q <= (rsp_sel == RSP_NONE) ? ST_IDLE : ST_GAP;
          end
        end
        ST_GAP: begin
          if (sd_fall) begin
            gap_q <= gap_q + 1'b1;
          end
          if (tx_load) begin
            cmd_out  <= tx_img[LONG_LEN-1];                        // [R12]
            cmd_oe   <= 1'b1;
            tx_q     <= {tx_img[LONG_LEN-2:0], 1'b1};              // [R11]
            tx_cnt_q <= tx_len;
            state_q  <= ST_TX;
          end
        end
        ST_TX: begin
          if (sd_fall) begin
            if (tx_cnt_q == 8'h00) begin
              cmd_oe  <= 1'b0;
              cmd_out <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              cmd_out  <= tx_q[LONG_LEN-1];                        // [R12]
              tx_q     <= {tx_q[LONG_LEN-2:0], 1'b1};
              tx_cnt_q <= tx_cnt_q - 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign card_ready = init_done_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_tx_start;
    tx_load && clk_en;
  endsequence

  property p_busy_low;
    !init_done_q |-> (ocr_word[OCR_BUSY_BIT] == 1'b0) && (ocr_word[OCR_CCS_BIT] == 1'b0);
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy bit set early"); // [R01]

  property p_busy_time;
    $rose(init_done_q) |-> $past(init_cnt_q) == INIT_LAST;
  endproperty
  a_busy_time: assert property (p_busy_time) else $error("ready at wrong time"); // [R01]

  property p_vwin;
    ocr_word[OCR_VWIN_MSB:OCR_VWIN_LSB] == OCR_VWIN_ALL;
  endproperty
  a_vwin: assert property (p_vwin) else $error("voltage window wrong"); // [R02]

  property p_low_voltage_switch_ok;
    ocr_word[OCR_LOW_VOLTAGE_SWITCH_OK_BIT] == 1'b0;
  endproperty
  a_low_voltage_switch_ok: assert property (p_low_voltage_switch_ok) else $error("low voltage flag set"); // [R03]

  property p_ocr_rsv;
    (ocr_word[29:25] == 5'h00) && (ocr_word[14:0] == 15'h0000);
  endproperty
  a_ocr_rsv: assert property (p_ocr_rsv) else $error("reserved bits set"); // [R04]

  property p_cid_fields;
    (cid_word[127:CID_MID_LSB] == MAKER_CODE) && (cid_word[119:CID_OID_LSB] == OEM_CODE)
      && (cid_word[103:CID_PNM_LSB] == PRODUCT_NAME) && (cid_word[63:CID_PRV_LSB] == PRODUCT_REV);
  endproperty
  a_cid_fields: assert property (p_cid_fields) else $error("id fields misplaced"); // [R05]

  property p_cid_lot;
    (cid_word[55:CID_PSN_LSB] == SERIAL_NUM) && (cid_word[23:CID_RSV_LSB] == 4'h0)
      && (cid_word[19:CID_MDT_LSB] == MFG_DATE);
  endproperty
  a_cid_lot: assert property (p_cid_lot) else $error("serial or date wrong"); // [R06]

  property p_cid_crc;
    cid_word[0] && (cid_word[7:CID_CRC_LSB] == crc7(cid_word[127:8]));
  endproperty
  a_cid_crc: assert property (p_cid_crc) else $error("id checksum wrong"); // [R07]

  property p_no_drv_stage;
    (rx_done && clk_en && cmd_idx == CMD_DRV_STAGE) |=> ((state_q == ST_IDLE) && !cmd_oe) [*8];
  endproperty
  a_no_drv_stage: assert property (p_no_drv_stage) else $error("answered stage cmd"); // [R09]

  property p_cid_reply;
    (s_tx_start and (rsp_q == RSP_LONG) && (raddr_q == MW_CID))
      |-> (tx_img[LONG_LEN-9:1] == cid_word[CID_W-1:1])
        && (tx_img[LONG_LEN-1:LONG_LEN-8] == 8'h3F);
  endproperty
  a_cid_reply: assert property (p_cid_reply) else $error("id reply wrong"); // [R11]

  property p_msb_first;
    s_tx_start |=> cmd_oe && (cmd_out == $past(tx_img[LONG_LEN-1]))
      && (tx_q[LONG_LEN-1] == $past(tx_img[LONG_LEN-2]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("not msb first"); // [R12]

endmodule

// File: sdci_card_info_tb.sv
`timescale 1ns/100ps
module sdci_card_info_tb import sdci_pkg::*; ;
  localparam logic [31:0]  SER = 32'h1234_5678;
  localparam logic [11:0]  MANUFACTURE_DATE_FIELD = 12'h3C5;
  localparam logic [127:0] CARD_SPECIFIC_DATA_WORD = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3211;
  localparam logic [119:0] CID_TOP = {8'h5A, 16'h4B4C, 40'h4D_4E_4F_50_51, 8'h10, SER,
                                      4'h0, MANUFACTURE_DATE_FIELD};
  localparam logic [31:0]  OCR_EXP = {1'b1, 1'b0, 5'h00, 1'b0, 9'h1FF, 15'h0000};

  logic         sys_clk;
  logic         rst_n;
  logic         clk_en;
  logic         sd_clk;
  logic         host_drv;
  logic         host_oe;
  logic         cmd_out;
  logic         cmd_oe;
  logic         card_ready;
  wire logic    cmd_wire;
  logic [135:0] r;
  logic [127:0] card_identification_word;
  int           fails;
  int           samples_checked;

  // Wire level: card, else host, else pull-up
  assign cmd_wire = cmd_oe ? cmd_out : (host_oe ? host_drv : 1'b1);

  sdci_card_info #(.SERIAL_NUM(SER), .MFG_DATE(MANUFACTURE_DATE_FIELD), .CSD_IMAGE(CARD_SPECIFIC_DATA_WORD)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .sd_clk_pin(sd_clk),
    .cmd_in(cmd_wire), .cmd_out(cmd_out), .cmd_oe(cmd_oe), .card_ready(card_ready));

  sdci_host_model host_u (
    .sd_clk(sd_clk), .host_drv(host_drv), .host_oe(host_oe), .cmd_wire(cmd_wire));

  // 200 MHz system clock
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  task automatic check(input logic [135:0] seen, input logic [135:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Expected 48-bit reply with its checksum, zero extended
  function automatic logic [135:0] short_rsp(input logic [5:0] idx, input logic [31:0] a);
    return {88'h0, 2'b00, idx, a, host_u.crc_calc({80'h0, 2'b00, idx, a}), 1'b1};
  endfunction

  // Random freeze of the whole card while the link is idle
  task automatic gap();
    @(negedge sys_clk) clk_en = 1'b0;
    repeat ($urandom_range(1, 6)) @(negedge sys_clk);
    clk_en = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask

  // Reset sequence and ready timing, used at start and in mid-run
  task automatic do_reset();
    @(negedge sys_clk) rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(136'({cmd_oe, cmd_out, card_ready}), 136'h2);
    rst_n = 1'b1;
    repeat (INIT_CYCLES - 10) @(negedge sys_clk);
    check(136'(card_ready), 136'h0);
    repeat (20) @(negedge sys_clk);
    check(136'(card_ready), 136'h1);
  endtask

  // Hang guard
  initial begin
    #400us;
    fails++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    fails = 0;
    samples_checked = 0;
    card_identification_word = {CID_TOP, host_u.crc_calc(CID_TOP), 1'b1};
    void'($urandom(32'h5d4c));
    do_reset();
    // Host keeps asking until the busy bit shows done, bounded
    r = '0;
    for (int k = 0; k < 20 && r[39] !== 1'b1; k++) begin
      host_u.xfer(CMD_APP, $urandom, 48);
      check(host_u.rsp_q, short_rsp(CMD_APP, R1_APP_STATUS));
      host_u.xfer(ACMD_OP_COND, $urandom, 48);
      r = host_u.rsp_q;
      gap();
    end
    check(r, {88'h0, 2'b00, 6'h3F, OCR_EXP, 7'h7F, 1'b1});
    check(136'(r[39:38]), 136'h2);
    check(136'(r[31:23]), 136'h1FF);
    check(136'(r[32]), 136'h0);
    check(136'({r[37:33], r[22:8]}), 136'h0);
    // Both identification queries, back to back
    for (int k = 0; k < 2; k++) begin
      host_u.xfer(k ? CMD_SEND_CID : CMD_ALL_CID, $urandom, 136);
      r = host_u.rsp_q;
      check(r, {2'b00, 6'h3F, card_identification_word[127:1], 1'b1});
      check(136'(r[127:56]), 136'(CID_TOP[119:48]));
      check(136'({r[55:20], r[19:8]}), 136'({SER, 4'h0, MANUFACTURE_DATE_FIELD}));
      check(136'(r[7:0]), 136'({host_u.crc_calc(CID_TOP), 1'b1}));
      gap();
    end
    host_u.xfer(CMD_SEND_CSD, $urandom, 136);
    check(host_u.rsp_q, {2'b00, 6'h3F, CARD_SPECIFIC_DATA_WORD[127:1], 1'b1});
    host_u.xfer(CMD_SEND_RCA, $urandom, 48);
    check(host_u.rsp_q, short_rsp(CMD_SEND_RCA, {16'h0001, 16'h0000}));
    // Silent commands: driver stage, idle, unprefixed and broken-prefix query
    host_u.xfer(CMD_DRV_STAGE, $urandom, 48);
    check(136'(host_u.got_q), 136'h0);
    host_u.xfer(CMD_GO_IDLE, 32'h0, 48);
    check(136'(host_u.got_q), 136'h0);
    host_u.xfer(ACMD_OP_COND, $urandom, 48);
    check(136'(host_u.got_q), 136'h0);
    host_u.xfer(CMD_APP, 32'h0, 48);
    host_u.xfer(CMD_GO_IDLE, 32'h0, 48);
    host_u.xfer(ACMD_OP_COND, $urandom, 48);
    check(136'(host_u.got_q), 136'h0);
    // Reset again in mid-run, then the card answers again
    do_reset();
    host_u.xfer(CMD_ALL_CID, $urandom, 136);
    check(host_u.rsp_q, {2'b00, 6'h3F, card_identification_word[127:1], 1'b1});
    stop_test();
  end
endmodule

// File: sdci_host_model.sv
`timescale 1ns/100ps
module sdci_host_model (
  // Link pins, host side
  output logic      sd_clk,
  output logic      host_drv,
  output logic      host_oe,
  input  wire logic cmd_wire
);
  logic [135:0] rsp_q;
  logic         got_q;

  // Own checksum, x^7 + x^3 + 1, kept apart from the card's copy
  function automatic logic [6:0] crc_calc(input logic [119:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction

  // Clock parked low, line released to the pull-up
  initial begin
    sd_clk = 1'b0;
    host_drv = 1'b1;
    host_oe = 1'b0;
    got_q = 1'b0;
    rsp_q = '0;
  end

  // One link period of 64 ns
  task automatic tick();
    #32 sd_clk = 1'b1;
    #32 sd_clk = 1'b0;
  endtask

  // Whole command frame, then a bounded listen for the reply
  task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input int len);
    logic [47:0] f;
    f = {2'b01, idx, arg, 8'h01};
    f[7:1] = crc_calc({80'h0, f[47:8]});
    host_oe = 1'b1;
    for (int i = 47; i >= 0; i--) begin
      host_drv = f[i];
      tick();
    end
    host_oe = 1'b0;
    host_drv = 1'b1;
    got_q = 1'b0;
    rsp_q = '0;
    // Bounded wait for a start bit; no reply leaves got_q low
    for (int n = 0; n < 10 && !got_q; n++) begin
      #32 sd_clk = 1'b1;
      got_q = (cmd_wire === 1'b0);
      #32 sd_clk = 1'b0;
    end
    // Reply taken at rising edges, first bit lands highest
    if (got_q)
      for (int i = 1; i < len; i++) begin
        #32 sd_clk = 1'b1;
        rsp_q = {rsp_q[134:0], cmd_wire};
        #32 sd_clk = 1'b0;
      end
    repeat (3) tick();
  endtask
endmodule

// File: sdci_pkg.sv
// Function
// R01 - Busy bit 31 low until init done; bit30 zero
// R02 - Voltage window bits 23..15 all read one
// R03 - Low-voltage switch flag bit 24 reads zero
// R04 - Reserved conditions bits read zero
// R05 - Identification word 128 bits, maker/OEM/name/revision fields
// R06 - Serial 55..24, date 19..8, 23..20 zero
// R07 - Checksum in bits 7..1, bit 0 one
// R08 - Provide all card registers at listed widths; configuration and status words are stored but never read out
// R09 - No driver-stage register, no strength programming
// R10 - Host repeats condition query until ready
// R11 - Identification query returns full identification word
// R12 - Register contents shift out MSB first
package sdci_pkg;

  // Clock and power-up timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int INIT_TIME_NS  = 1000;
  localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CNT_W    = 16;
  localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_CYCLES - 1);

  // Register widths
  localparam int OCR_W = 32;
  localparam int CID_W = 128;
  localparam int CSD_W = 128;
  localparam int RCA_W = 16;
  localparam int SCR_W = 64;
  localparam int SSR_W = 512;

  // Operating-conditions word layout
  localparam int OCR_BUSY_BIT = 31;
  localparam int OCR_CCS_BIT  = 30;
  localparam int OCR_LOW_VOLTAGE_SWITCH_OK_BIT = 24;
  localparam int OCR_VWIN_MSB = 23;
  localparam int OCR_VWIN_LSB = 15;
  localparam logic [8:0] OCR_VWIN_ALL = 9'h1FF;

  // Identification word layout
  localparam int CID_MID_LSB = 120;
  localparam int CID_OID_LSB = 104;
  localparam int CID_PNM_LSB = 64;
  localparam int CID_PRV_LSB = 56;
  localparam int CID_PSN_LSB = 24;
  localparam int CID_RSV_LSB = 20;
  localparam int CID_MDT_LSB = 8;
  localparam int CID_CRC_LSB = 1;

  // Link framing
  localparam int CMD_LEN   = 48;
  localparam int LONG_LEN  = 136;
  localparam int NCR_EDGES = 2;
  localparam logic [5:0] IDX_ALL_ONES = 6'h3F;
  localparam logic [6:0] CRC_ALL_ONES = 7'h7F;
  localparam logic [31:0] R1_APP_STATUS = 32'h0000_0020;

  // Command indexes
  localparam logic [5:0] CMD_GO_IDLE   = 6'h00;
  localparam logic [5:0] CMD_ALL_CID   = 6'h02;
  localparam logic [5:0] CMD_SEND_RCA  = 6'h03;
  localparam logic [5:0] CMD_DRV_STAGE = 6'h04;
  localparam logic [5:0] CMD_SEND_CSD  = 6'h09;
  localparam logic [5:0] CMD_SEND_CID  = 6'h0A;
  localparam logic [5:0] CMD_APP       = 6'h37;
  localparam logic [5:0] ACMD_OP_COND  = 6'h29;

  // Word store map, 128-bit words
  localparam int MW_AW = 3;
  localparam int MW_DEPTH = 8;
  localparam logic [MW_AW-1:0] MW_CID  = 3'h0;
  localparam logic [MW_AW-1:0] MW_CSD  = 3'h1;
  localparam logic [MW_AW-1:0] MW_SCR  = 3'h2;
  localparam logic [MW_AW-1:0] MW_SSR0 = 3'h3;
  localparam logic [MW_AW-1:0] MW_LAST = 3'h6;

  typedef enum logic [1:0] {RSP_NONE, RSP_SHORT, RSP_OCR, RSP_LONG} sdci_rsp_t;

  // Seven-bit checksum, polynomial x^7 + x^3 + 1; leading zeros do not change it
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction

endpackage

// File: sdci_word_mem.sv
`timescale 1ns/100ps
module sdci_word_mem #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic             sys_clk,
  input  wire logic             clk_en,
  // Write side
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read side
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Registered read, one cycle behind the address
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (we) begin
        mem_q[waddr] <= wdata;
      end
      rdata <= mem_q[raddr];
    end
  end

endmodule
